//--- gfo_pkg.sv
// Overview of operation
// RL1 - Pins one to four selectable as tracking sense
// RL2 - Pulldown bits 7..4 enable sense pulldowns
// RL3 - Output data bits drive logic output pins
// RL4 - Input state register read-only, shows pin levels
// RL5 - Data registers not loaded from nonvolatile memory
// RL6 - Combined fault on pins 1-4, active low
// RL7 - Pin five fault A, pin six fault B
// RL8 - Dedicated fault is OR of selected conditions
// RL9 - Fault A low select covers channels 1-8
// RL10 - Fault A high select covers channels 9-12
// RL11 - Bits 4..6 enable over, under, warning
// RL12 - Bit 7 selects fault A polarity
// RL13 - Fault B low select covers channels 1-8
// RL14 - Fault B high register mirrors fault A layout
// RL15 - Three-bit field selects each pin mode
// RL16 - Margin freezes fault outputs, ignores violations
// RL17 - Open-drain drives low only, else releases
// RL18 - Pin levels pass two-stage synchroniser
package gfo_pkg;

   localparam int NPIN = 6;
   localparam int NCH  = 12;

   // Register offsets.
   localparam logic [7:0] OFS_FA_LO   = 8'h15;
   localparam logic [7:0] OFS_FA_HI   = 8'h16;
   localparam logic [7:0] OFS_FB_LO   = 8'h17;
   localparam logic [7:0] OFS_FB_HI   = 8'h18;
   localparam logic [7:0] OFS_OUT     = 8'h1a;
   localparam logic [7:0] OFS_IN      = 8'h1b;
   localparam logic [7:0] OFS_CFG0    = 8'h1c;
   localparam logic [7:0] OFS_CFG1    = 8'h1d;
   localparam logic [7:0] OFS_CFG2    = 8'h1e;
   localparam logic [7:0] OFS_MARGIN  = 8'h4d;
   localparam logic [7:0] OFS_PULLDN  = 8'h4e;
   localparam logic [7:0] OFS_IRQ_ST  = 8'h60;
   localparam logic [7:0] OFS_IRQ_EN  = 8'h61;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h62;

   // Field positions.
   localparam int HI_CH_LSB   = 0;
   localparam int HI_OV_BIT   = 4;
   localparam int HI_UV_BIT   = 5;
   localparam int HI_EW_BIT   = 6;
   localparam int HI_POL_BIT  = 7;
   localparam int PD_LSB      = 4;
   localparam int MARGIN_BIT  = 1;

   // Reset values.
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [17:0] RST_CFG  = 18'h0_9249; // Every pin a push-pull logic pin.

   // Interrupt status bits.
   localparam int IRQ_ANY = 0;
   localparam int IRQ_FA  = 1;
   localparam int IRQ_FB  = 2;

   typedef enum logic [2:0] {
      GFO_MODE_SENSE  = 3'b000,
      GFO_MODE_PP     = 3'b001,
      GFO_MODE_OD     = 3'b010,
      GFO_MODE_PPF    = 3'b011,
      GFO_MODE_ODF    = 3'b100,
      GFO_MODE_IN     = 3'b101,
      GFO_MODE_RSV6   = 3'b110,
      GFO_MODE_RSV7   = 3'b111
   } gfo_mode_e;

   // Per-channel threshold flags from the monitoring block.
   typedef struct packed {
      logic [NCH-1:0] ov;
      logic [NCH-1:0] uv;
      logic [NCH-1:0] ew;
   } gfo_flags_s;

   // Drive value and drive enable for every pin.
   typedef struct packed {
      logic [NPIN-1:0] o;
      logic [NPIN-1:0] oe;
   } gfo_pin_s;

endpackage : gfo_pkg

//--- gfo_gpio_fault.sv
// Chosen here: strobed register access.
`timescale 1ns/1ps
module gfo_gpio_fault
   import gfo_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [7:0]       reg_rdata,
   input  wire gfo_flags_s       mon_flags,
   input  wire logic [NPIN-1:0]  pin_i,
   output gfo_pin_s              pin,
   output logic      [3:0]       sense_select,
   output logic      [3:0]       sense_pulldown_en,
   output logic                  irq
);

   logic [7:0]  fa_lo_reg, fa_hi_reg, fb_lo_reg, fb_hi_reg;
   logic [7:0]  out_reg, pulldn_reg, margin_reg;
   logic [17:0] cfg_reg;
   logic [NPIN-1:0] sync1_reg, sync2_reg;
   logic        any_reg, fa_reg, fb_reg;
   logic [2:0]  irq_st_reg, irq_en_reg;
   logic        any_next, fa_next, fb_next;
   logic        margin;

   // Mode field of pin n out of the packed configuration word.
   function automatic gfo_mode_e pin_mode(input logic [17:0] c, input int n);
      pin_mode = gfo_mode_e'(c[3*n +: 3]);
   endfunction : pin_mode

   // Fault term from a channel set and its condition and polarity byte.
   function automatic logic sel_fault(input logic [7:0] lo, input logic [7:0] hi,
                                      input gfo_flags_s f);
      logic [NCH-1:0] chs;
      chs = {hi[HI_CH_LSB +: 4], lo};                          // [RL9] [RL10] [RL13] [RL14]
      sel_fault = (hi[HI_OV_BIT] && |(chs & f.ov))             // [RL11]
               || (hi[HI_UV_BIT] && |(chs & f.uv))
               || (hi[HI_EW_BIT] && |(chs & f.ew));            // [RL8]
   endfunction : sel_fault

   // Margin comes from the control bit or a low level on a pin six margin input.
   assign margin = margin_reg[MARGIN_BIT]
                || (pin_mode(cfg_reg, 5) == GFO_MODE_SENSE && !sync2_reg[5]);

   // Raw fault terms, active high.
   assign any_next = |{mon_flags.ov, mon_flags.uv, mon_flags.ew};
   assign fa_next  = sel_fault(fa_lo_reg, fa_hi_reg, mon_flags);
   assign fb_next  = sel_fault(fb_lo_reg, fb_hi_reg, mon_flags);

   // Register writes; data registers clear on reset except cfg_reg, set to RST_CFG; never loaded from storage.
   always_ff @(posedge clk_sys) begin
      if (rst) begin                                            // [RL5]
         fa_lo_reg  <= RST_BYTE;
         fa_hi_reg  <= RST_BYTE;
         fb_lo_reg  <= RST_BYTE;
         fb_hi_reg  <= RST_BYTE;
         out_reg    <= RST_BYTE;
         pulldn_reg <= RST_BYTE;
         margin_reg <= RST_BYTE;
         cfg_reg    <= RST_CFG;
         irq_en_reg <= 3'h0;
      end else if (reg_wr) begin
         if (reg_addr == OFS_FA_LO) begin
            fa_lo_reg <= reg_wdata;
         end else if (reg_addr == OFS_FA_HI) begin
            fa_hi_reg <= reg_wdata;
         end else if (reg_addr == OFS_FB_LO) begin
            fb_lo_reg <= reg_wdata;
         end else if (reg_addr == OFS_FB_HI) begin
            fb_hi_reg <= reg_wdata;
         end else if (reg_addr == OFS_OUT) begin
            out_reg <= {2'b00, reg_wdata[5:0]};                 // [RL3]
         end else if (reg_addr == OFS_CFG0) begin
            cfg_reg[7:0] <= reg_wdata;
         end else if (reg_addr == OFS_CFG1) begin
            cfg_reg[15:8] <= reg_wdata;
         end else if (reg_addr == OFS_CFG2) begin
            cfg_reg[17:16] <= reg_wdata[1:0];
         end else if (reg_addr == OFS_MARGIN) begin
            margin_reg <= reg_wdata;
         end else if (reg_addr == OFS_PULLDN) begin
            pulldn_reg <= reg_wdata;
         end else if (reg_addr == OFS_IRQ_EN) begin
            irq_en_reg <= reg_wdata[2:0];
         end
      end
   end

   // Two-stage synchroniser on pin levels.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= pin_i;                                    // [RL18]
         sync2_reg <= sync1_reg;
      end
   end

   // Fault state; held unchanged while margin is active.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         any_reg <= 1'b0;
         fa_reg  <= 1'b0;
         fb_reg  <= 1'b0;
      end else if (!margin) begin                               // [RL16]
         any_reg <= any_next;
         fa_reg  <= fa_next;
         fb_reg  <= fb_next;
      end
   end

   // Sticky interrupt status; a new event wins over a clear.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq_st_reg <= 3'h0;
      end else begin
         irq_st_reg <= (irq_st_reg & ~((reg_wr && reg_addr == OFS_IRQ_CLR)
                                        ? reg_wdata[2:0] : 3'h0))
                     | {fb_reg, fa_reg, any_reg};
      end
   end

   assign irq = |(irq_st_reg & irq_en_reg);

   // Read data, one cycle after the strobe; unmapped reads return zero.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata <= RST_BYTE;
      end else if (reg_rd) begin
         if (reg_addr == OFS_FA_LO) begin
            reg_rdata <= fa_lo_reg;
         end else if (reg_addr == OFS_FA_HI) begin
            reg_rdata <= fa_hi_reg;
         end else if (reg_addr == OFS_FB_LO) begin
            reg_rdata <= fb_lo_reg;
         end else if (reg_addr == OFS_FB_HI) begin
            reg_rdata <= fb_hi_reg;
         end else if (reg_addr == OFS_OUT) begin
            reg_rdata <= out_reg;
         end else if (reg_addr == OFS_IN) begin
            reg_rdata <= {2'b00, sync2_reg};                    // [RL4]
         end else if (reg_addr == OFS_CFG0) begin
            reg_rdata <= cfg_reg[7:0];
         end else if (reg_addr == OFS_CFG1) begin
            reg_rdata <= cfg_reg[15:8];
         end else if (reg_addr == OFS_CFG2) begin
            reg_rdata <= {6'h00, cfg_reg[17:16]};
         end else if (reg_addr == OFS_MARGIN) begin
            reg_rdata <= margin_reg;
         end else if (reg_addr == OFS_PULLDN) begin
            reg_rdata <= pulldn_reg;
         end else if (reg_addr == OFS_IRQ_ST) begin
            reg_rdata <= {5'h00, irq_st_reg};
         end else if (reg_addr == OFS_IRQ_EN) begin
            reg_rdata <= {5'h00, irq_en_reg};
         end else begin
            reg_rdata <= RST_BYTE;
         end
      end
   end

   // Pin drivers, one per pin.
   genvar g;
   generate
      for (g = 0; g < NPIN; g++) begin : g_pin
         logic flt_lvl;   // Pin level while in a fault mode.
         if (g < 4) begin : g_any
            assign flt_lvl = !any_reg;                          // [RL6]
         end else if (g == 4) begin : g_fa
            assign flt_lvl = fa_reg ~^ fa_hi_reg[HI_POL_BIT];   // [RL7] [RL12]
         end else begin : g_fb
            assign flt_lvl = fb_reg ~^ fb_hi_reg[HI_POL_BIT];   // [RL7] [RL14]
         end
         always_comb begin
            pin.o[g]  = 1'b0;
            pin.oe[g] = 1'b0;
            case (pin_mode(cfg_reg, g))                         // [RL15]
               GFO_MODE_PP: begin
                  pin.o[g]  = out_reg[g];                       // [RL3]
                  pin.oe[g] = 1'b1;
               end
               GFO_MODE_OD: begin
                  pin.oe[g] = !out_reg[g];                      // [RL17]
               end
               GFO_MODE_PPF: begin
                  pin.o[g]  = flt_lvl;
                  pin.oe[g] = 1'b1;
               end
               GFO_MODE_ODF: begin
                  pin.oe[g] = !flt_lvl;                         // [RL17]
               end
               default: begin
                  pin.oe[g] = 1'b0;
               end
            endcase
         end
      end
   endgenerate

   // Sense selection and pulldowns for pins one to four.
   generate
      for (g = 0; g < 4; g++) begin : g_sense
         assign sense_select[g]      = (pin_mode(cfg_reg, g) == GFO_MODE_SENSE);   // [RL1]
         assign sense_pulldown_en[g] = pulldn_reg[PD_LSB + g];                     // [RL2]
      end
   endgenerate

endmodule : gfo_gpio_fault

//--- gfo_gpio_fault_monitor.sv
`timescale 1ns/1ps
module gfo_gpio_fault_monitor
   import gfo_pkg::*;
(
   input wire logic            clk_sys,
   input wire logic            rst,
   input wire logic [7:0]      reg_addr,
   input wire logic [7:0]      reg_wdata,
   input wire logic            reg_wr,
   input wire logic            reg_rd,
   input wire logic [7:0]      reg_rdata,
   input wire gfo_flags_s      mon_flags,
   input wire logic [NPIN-1:0] pin_i,
   input wire gfo_pin_s        pin,
   input wire logic [3:0]      sense_select,
   input wire logic [3:0]      sense_pulldown_en,
   input wire logic            irq
);
   logic [7:0]  sh [256];
   logic [17:0] cfg;
   logic [5:0]  pp_m, od_m, in_m, pf_m, se_m;
   logic        mrg, ha, hb, any;
   logic [2:0]  up;
   logic [1:0]  p6;
   // A fault output asserts when a selected channel has an enabled flag.
   function automatic logic hit(logic [7:0] lo, logic [7:0] hi, gfo_flags_s f);
      logic [11:0] c;
      c = {hi[3:0], lo};
      return |(c & ({12{hi[4]}} & f.ov | {12{hi[5]}} & f.uv | {12{hi[6]}} & f.ew));
   endfunction : hit
   // Shadow of every byte written, plus cycles since reset, saturating at seven.
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < 256; i++) begin
         if (rst) sh[i] <= RST_BYTE;
         else if (reg_wr && reg_addr == 8'(i)) sh[i] <= reg_wdata;
      end
      if (rst) sh[OFS_CFG0] <= RST_CFG[7:0];
      if (rst) sh[OFS_CFG1] <= RST_CFG[15:8];
      up <= rst ? 3'h0 : (up == 3'h7 ? up : up + 3'h1);
      p6 <= rst ? 2'h0 : {p6[0], pin_i[5]};
   end
   // Pin mode masks and the expected fault conditions.
   assign cfg = {sh[OFS_CFG2][1:0], sh[OFS_CFG1], sh[OFS_CFG0]};
   always_comb begin
      for (int p = 0; p < 6; p++) begin
         pp_m[p] = cfg[3*p+:3] == GFO_MODE_PP;
         od_m[p] = cfg[3*p+:3] == GFO_MODE_OD;
         in_m[p] = cfg[3*p+:3] == GFO_MODE_IN;
         pf_m[p] = cfg[3*p+:3] == GFO_MODE_PPF;
         se_m[p] = cfg[3*p+:3] == GFO_MODE_SENSE;
      end
   end
   assign mrg = sh[OFS_MARGIN][MARGIN_BIT] || (se_m[5] && !p6[1]);
   assign ha  = hit(sh[OFS_FA_LO], sh[OFS_FA_HI], mon_flags);
   assign hb  = hit(sh[OFS_FB_LO], sh[OFS_FB_HI], mon_flags);
   assign any = |{mon_flags.ov, mon_flags.uv, mon_flags.ew};
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence calm;
      $stable(mon_flags) && !mrg && !$past(mrg) && !$past(reg_wr) && up > 3'h1;
   endsequence
   a_rdata_pad: assert property (reg_rd && (reg_addr == OFS_OUT || reg_addr == OFS_IN)
      |=> reg_rdata[7:6] == 2'h0) else $error("unused data bits set");
   a_in_sync: assert property (reg_rd && reg_addr == OFS_IN && up > 3'h4 && $stable(pin_i)
      && pin_i == $past(pin_i, 2) && pin_i == $past(pin_i, 3) |=> reg_rdata[5:0] == $past(pin_i))
      else $error("input state read wrong");
   a_pd_map: assert property (sense_pulldown_en == sh[OFS_PULLDN][PD_LSB+:4])
      else $error("pulldown enables wrong");
   a_sense_sel: assert property (sense_select == se_m[3:0]) else $error("sense select wrong");
   a_pp_data: assert property ((pin.oe & pp_m) == pp_m
      && (pin.o & pp_m) == (sh[OFS_OUT][5:0] & pp_m)) else $error("push-pull data wrong");
   a_od_low: assert property ((pin.o & od_m) == 6'h00
      && (pin.oe & od_m) == (~sh[OFS_OUT][5:0] & od_m)) else $error("open-drain drive wrong");
   a_in_float: assert property ((pin.oe & in_m) == 6'h00) else $error("input pin driven");
   a_any_fault: assert property (calm |-> (pin.o[3:0] & pf_m[3:0]) == ({4{!any}} & pf_m[3:0]))
      else $error("combined fault level wrong");
   a_fault_a: assert property (calm and pf_m[4] |-> pin.o[4] == (ha ~^ sh[OFS_FA_HI][7]))
      else $error("fault a level wrong");
   a_fault_b: assert property (calm and cfg[17:15] == GFO_MODE_ODF
      |-> (pin.oe[5] ? pin.o[5] : 1'b1) == (hb ~^ sh[OFS_FB_HI][7])) else $error("fault b level wrong");
   a_margin_hold: assert property (mrg && $past(mrg) && !$past(reg_wr) && up > 3'h1
      |-> $stable(pin.o)) else $error("fault output moved in margin");
   a_irq_mask: assert property (irq |-> sh[OFS_IRQ_EN][2:0] != 3'h0) else $error("irq while masked");
   c_fault_a: cover property (pf_m[4] && ha);
   c_margin: cover property (mrg && any);
   c_in_read: cover property (reg_rd && reg_addr == OFS_IN);
endmodule : gfo_gpio_fault_monitor

bind gfo_gpio_fault gfo_gpio_fault_monitor mon (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .mon_flags(mon_flags), .pin_i(pin_i), .pin(pin), .sense_select(sense_select),
   .sense_pulldown_en(sense_pulldown_en), .irq(irq));

//--- gfo_board.sv
`timescale 1ns/1ps
module gfo_board
   import gfo_pkg::*;
(
   input  wire gfo_pin_s        pin,
   input  wire logic [NPIN-1:0] ext_val,
   input  wire logic            ext_en,
   output logic      [NPIN-1:0] pin_i
);
   // Each wire shows the device drive, else the board drive, else its pull-up.
   always_comb begin
      for (int p = 0; p < NPIN; p++) begin
         pin_i[p] = pin.oe[p] ? pin.o[p] : (ext_en ? ext_val[p] : 1'b1);
      end
   end
endmodule : gfo_board

//--- tb.sv
`timescale 1ns/1ps
module tb
   import gfo_pkg::*;
;
   logic       clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
   logic       ext_en = 1'b0, irq, pol;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
   logic [5:0] ext_val = 6'h00, pin_i;
   logic [3:0] sense_select, sense_pulldown_en;
   gfo_flags_s flags = '0;
   gfo_pin_s   pin;
   logic [7:0] exq [$];
   logic [7:0] ra [8] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h1a, 8'h4e, 8'h1e, 8'h30};
   int         errors = 0, n_checks = 0, cyc = 0;
   always #5 clk_sys = ~clk_sys;
   gfo_gpio_fault dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mon_flags(flags), .pin_i(pin_i),
      .pin(pin), .sense_select(sense_select), .sense_pulldown_en(sense_pulldown_en), .irq(irq));
   gfo_board bd (.pin(pin), .ext_val(ext_val), .ext_en(ext_en), .pin_i(pin_i));
   task summarize;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize
   task chk(string n, logic [7:0] e, logic [7:0] s);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task wr(logic [7:0] a, logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(logic [7:0] a, logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exq.push_back(e);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask : rd
   task settle;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask : settle
   task cfgw(logic [17:0] v);
      wr(OFS_CFG0, v[7:0]);
      wr(OFS_CFG1, v[15:8]);
      wr(OFS_CFG2, {6'h00, v[17:16]});
   endtask : cfgw
   // Drive one condition on channels one and nine, then check the pins.
   task fault(int c, logic a);
      @(posedge clk_sys);
      flags <= gfo_flags_s'(36'h101 << (12 * (2 - c)));
      settle();
      chk("pin_o", {3'h0, a ? pol : !pol, 4'h0}, {2'h0, pin.o});
      chk("pin_oe6", 8'h01, {7'h0, pin.oe[5]});
   endtask : fault
   // Each read answer is compared with the oldest noted value.
   always @(posedge clk_sys) rd_d <= reg_rd;
   always @(negedge clk_sys) if (rd_d) chk("rdata", exq.pop_front(), reg_rdata);
   // The run is cut short if it hangs.
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         summarize();
      end
   end
   initial begin
      void'($urandom(48212));
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      foreach (ra[i]) rd(ra[i], 8'h00);
      rd(OFS_CFG0, 8'h49);
      rd(OFS_CFG1, 8'h92);
      $display("reset values done");
      d = 8'($urandom);
      wr(OFS_OUT, d);
      wr(OFS_IN, 8'hff);
      settle();
      chk("pin_o", d & 8'h3f, {2'h0, pin.o});
      rd(OFS_OUT, d & 8'h3f);
      rd(OFS_IN, d & 8'h3f);
      cfgw(18'h1_2492);
      settle();
      chk("pin_oe", ~d & 8'h3f, {2'h0, pin.oe});
      rd(OFS_IN, d & 8'h3f);
      $display("logic outputs done");
      cfgw(18'h2_db6d);
      ext_en <= 1'b1;
      ext_val <= 6'($urandom);
      settle();
      rd(OFS_IN, {2'h0, ext_val});
      ext_en <= 1'b0;
      cfgw(18'h0_0000);
      wr(OFS_PULLDN, d);
      settle();
      chk("sense", 8'h0f, {4'h0, sense_select});
      chk("pulldown", {4'h0, d[7:4]}, {4'h0, sense_pulldown_en});
      $display("inputs and sense done");
      cfgw(18'h2_36db);
      wr(OFS_FA_LO, 8'h00);
      wr(OFS_FB_LO, 8'h01);
      wr(OFS_FB_HI, 8'h70);
      for (int c = 0; c < 3; c++) begin
         pol = 1'($urandom);
         wr(OFS_FA_HI, {pol, 3'(1 << c), 4'h1});
         fault(c, 1'b1);
         fault((c + 1) % 3, 1'b0);
      end
      @(posedge clk_sys);
      flags <= '0;
      settle();
      chk("pin_idle", {3'h0, !pol, 4'hf}, {2'h0, pin.o});
      chk("pin_oe6", 8'h00, {7'h0, pin.oe[5]});
      $display("fault outputs done");
      wr(OFS_FA_HI, 8'h11);
      flags <= gfo_flags_s'(36'h101 << 24);
      settle();
      wr(OFS_MARGIN, 8'h02);
      flags <= '0;
      settle();
      chk("margin", 8'h00, {2'h0, pin.o});
      wr(OFS_MARGIN, 8'h00);
      settle();
      chk("unmargin", 8'h1f, {2'h0, pin.o});
      // A low level on pin six in its margin input mode also freezes the faults.
      cfgw(18'h0_36db);
      ext_val <= 6'h00;
      ext_en <= 1'b1;
      settle();
      @(posedge clk_sys);
      flags <= gfo_flags_s'(36'h101 << 24);
      settle();
      chk("pin_margin", 8'h1f, {2'h0, pin.o});
      @(posedge clk_sys);
      ext_en <= 1'b0;
      settle();
      chk("pin_release", 8'h00, {2'h0, pin.o});
      @(posedge clk_sys);
      flags <= '0;
      settle();
      $display("margin done");
      wr(OFS_IRQ_EN, 8'h00);
      settle();
      chk("irq_off", 8'h00, {7'h0, irq});
      wr(OFS_IRQ_EN, 8'h07);
      settle();
      chk("irq_on", 8'h01, {7'h0, irq});
      rd(OFS_IRQ_ST, 8'h07);
      wr(OFS_IRQ_CLR, 8'h07);
      settle();
      chk("irq_clr", 8'h00, {7'h0, irq});
      rd(OFS_IRQ_ST, 8'h00);
      settle();
      $display("interrupts done");
      // A second reset in mid-run brings the registers back to their reset values.
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd(OFS_FA_HI, 8'h00);
      rd(OFS_CFG0, 8'h49);
      rd(OFS_IRQ_EN, 8'h00);
      settle();
      chk("irq_rst", 8'h00, {7'h0, irq});
      $display("second reset done");
      summarize();
   end
endmodule : tb
